// >>> src/tic_regs.svh
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH

// Operation codes and command descriptor lengths.
`define TIC_OP_LIMITS   8'h05
`define TIC_OP_RDBUF    8'h3C
`define TIC_GRP0        3'h0
`define TIC_GRP1        3'h1
`define TIC_LEN_GRP0    4'h6
`define TIC_LEN_GRP1    4'hA

// Block-limits record contents.
`define TIC_REC_LEN     24'h000006
`define TIC_MAX_LEN     24'h03C000
`define TIC_MAX_LEN_ND  24'h028000
`define TIC_MIN_LEN     16'h0001

// Microcode-image read fields.
`define TIC_MODE_IMAGE  3'h1
`define TIC_IMG_LEN     24'h054E28

// Sense keys.
`define TIC_SK_NONE     4'h0
`define TIC_SK_ILLEGAL  4'h5
`define TIC_SK_ABORTED  4'hB

// Controller register byte offsets.
`define TIC_CMD         12'h000
`define TIC_ALLOC       12'h004
`define TIC_STATUS      12'h008
`define TIC_IRQ_STAT    12'h00C
`define TIC_IRQ_MASK    12'h010
`define TIC_LIMITS_MAX  12'h014
`define TIC_LIMITS_MIN  12'h018

// Field positions and reset values.
`define TIC_CMD_GO      0
`define TIC_CMD_OP      1
`define TIC_CMD_BUSY    8
`define TIC_ALLOC_RST   27'h1054E28
`define TIC_IRQ_DONE    0
`define TIC_IRQ_CHECK   1

`endif

// >>> src/tic_pkg.sv
package tic_pkg;

    typedef enum logic [4:0] {
        TIC_D_IDLE   = 5'h01,
        TIC_D_CDB    = 5'h02,
        TIC_D_CHECK  = 5'h04,
        TIC_D_SEND   = 5'h08,
        TIC_D_STATUS = 5'h10
    } tic_dev_e;

    typedef enum logic [2:0] {
        TIC_H_IDLE = 3'h1,
        TIC_H_CDB  = 3'h2,
        TIC_H_WAIT = 3'h4
    } tic_host_e;

    typedef logic [7:0] tic_byte_t;

    typedef struct packed {
        tic_dev_e             st;
        tic_byte_t [9:0]      cdb;
        logic      [3:0]      idx;
        logic      [3:0]      len;
        logic      [23:0]     cnt;
        logic      [23:0]     total;
        logic                 img;
        logic                 cdb_ready;
        logic                 data_valid;
        tic_byte_t            data_byte;
        logic                 status_valid;
        logic                 status_check;
        logic      [3:0]      status_sense;
    } tic_dev_s;

    typedef struct packed {
        tic_host_e            st;
        logic      [3:0]      idx;
        logic                 op;
        logic                 cdb_valid;
        tic_byte_t            cdb_byte;
        logic      [26:0]     alloc;
        logic      [1:0]      irq_stat;
        logic      [1:0]      irq_mask;
        logic                 irq;
        logic                 check;
        logic      [3:0]      sense;
        logic      [23:0]     rx_cnt;
        logic      [23:0]     lim_max;
        logic      [15:0]     lim_min;
        logic                 rx_valid;
        tic_byte_t            rx_byte;
        logic                 take;
        logic                 bus_fault;
        logic                 pready;
        logic      [31:0]     prdata;
        logic                 pslverr;
    } tic_host_s;

endpackage

// >>> src/tic_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tic_if;
    logic       cdb_valid;
    logic [7:0] cdb_byte;
    logic       cdb_ready;
    logic       data_valid;
    logic [7:0] data_byte;
    logic       data_ready;
    logic       status_valid;
    logic       status_check;
    logic [3:0] status_sense;
    logic       bus_fault;

    modport dev (
        input  cdb_valid, cdb_byte, data_ready, bus_fault,
        output cdb_ready, data_valid, data_byte,
        output status_valid, status_check, status_sense
    );

    modport host (
        output cdb_valid, cdb_byte, data_ready, bus_fault,
        input  cdb_ready, data_valid, data_byte,
        input  status_valid, status_check, status_sense
    );
endinterface
`default_nettype wire

// >>> src/tic_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "tic_regs.svh"

// Function
// - Opcode 05h returns block length limits record.
// - Limits apply to fixed and variable modes.
// - Max bytes 1-3, min bytes 4-5, big-endian.
// - Max is 03C000h when no-disconnect clear.
// - Max is 28000h when no-disconnect set.
// - Minimum block length always 0001h.
// - Opcode 3Ch streams microcode image to initiator.
// - Mode field must be 001b, image read.
// - Initiator zeroes buffer selector and offset.
// - Allocation length must equal 54E28h bytes.
// - Other allocation length: check, illegal request.
// - Fault during image transfer: check, aborted command.
// - Initiator retries after aborted command.
// - Cloning: read image, then buffer writes.
// - Vendor bits of last byte ignored.
module tic_dev #(
    parameter logic [23:0] IMG_LEN = `TIC_IMG_LEN
) (
    input  wire logic                ref_clk_i,
    input  wire logic                arst_n_i,
    tic_if.dev                       link,
    input  wire logic                no_disconnect_during_transfer_i,
    input  wire logic                hw_fault_i,
    input  wire tic_pkg::tic_byte_t  img_data_i,
    output logic [18:0]              img_addr_o,
    output logic                     busy_o
);
    import tic_pkg::*;

    tic_dev_s s;
    tic_dev_s next_s;
    logic     busy;

    // The fault line is on another clock.
    // A change counts once stages two and three
    // agree, so a short glitch is ignored.
    logic [2:0] fault_sync;
    logic       fault_seen;

    // Block-limits record byte; the same limits serve both block modes.
    function automatic tic_byte_t rec_byte(input logic [2:0] i,
                                           input logic       nd);
        logic [23:0] max_len;
        logic [15:0] min_len;
        max_len = nd ? `TIC_MAX_LEN_ND : `TIC_MAX_LEN;
        min_len = `TIC_MIN_LEN;
        case (i)
            3'h1:    rec_byte = max_len[23:16];
            3'h2:    rec_byte = max_len[15:8];
            3'h3:    rec_byte = max_len[7:0];
            3'h4:    rec_byte = min_len[15:8];
            3'h5:    rec_byte = min_len[7:0];
            default: rec_byte = 8'h00;
        endcase
    endfunction

    // Only the fields that steer the command are looked at, so reserved
    // bits and the vendor bits of the last byte never change the outcome.
    function automatic logic rdbuf_ok(input tic_byte_t [9:0] c,
                                      input logic [23:0]     len);
        logic mode_ok;
        logic sel_ok;
        logic off_ok;
        logic alloc_ok;
        mode_ok  = (c[1][2:0] == `TIC_MODE_IMAGE);
        sel_ok   = (c[2] == 8'h00);
        off_ok   = ({c[3], c[4], c[5]} == 24'h000000);
        alloc_ok = ({c[6], c[7], c[8]} == len);
        rdbuf_ok = mode_ok && sel_ok && off_ok && alloc_ok;
    endfunction

    // The transfer is cut at the fifth rising edge
    // after the fault line rises.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_sync <= 3'h0;
            fault_seen <= 1'b0;
        end else begin
            fault_sync <= {fault_sync[1:0], hw_fault_i};
            if (fault_sync[1] == fault_sync[2]) begin
                fault_seen <= fault_sync[2];
            end
        end
    end

    always_comb begin
        next_s              = s;
        next_s.status_valid = 1'b0;
        busy                = (s.st != TIC_D_IDLE);
        case (s.st)
            TIC_D_IDLE: begin
                next_s.cdb_ready = 1'b1;
                if (link.cdb_valid && s.cdb_ready) begin
                    next_s.cdb[0] = link.cdb_byte;
                    next_s.idx    = 4'h1;
                    // The group code in the opcode sets the descriptor size.
                    if (link.cdb_byte[7:5] == `TIC_GRP1) begin
                        next_s.len = `TIC_LEN_GRP1;
                    end else begin
                        next_s.len = `TIC_LEN_GRP0;
                    end
                    next_s.st = TIC_D_CDB;
                end
            end
            TIC_D_CDB: begin
                if (link.cdb_valid && s.cdb_ready) begin
                    next_s.cdb[s.idx] = link.cdb_byte;
                    next_s.idx        = s.idx + 4'h1;
                    if (s.idx == s.len - 4'h1) begin
                        next_s.cdb_ready = 1'b0;
                        next_s.st        = TIC_D_CHECK;
                    end
                end
            end
            TIC_D_CHECK: begin
                next_s.cnt = 24'h000000;
                if (s.cdb[0] == `TIC_OP_LIMITS) begin
                    next_s.img   = 1'b0;
                    next_s.total = `TIC_REC_LEN;
                    next_s.st    = TIC_D_SEND;
                end else if (s.cdb[0] == `TIC_OP_RDBUF &&
                             rdbuf_ok(s.cdb, IMG_LEN)) begin
                    next_s.img   = 1'b1;
                    next_s.total = IMG_LEN;
                    next_s.st    = TIC_D_SEND;
                end else begin
                    next_s.status_check = 1'b1;
                    next_s.status_sense = `TIC_SK_ILLEGAL;
                    next_s.st           = TIC_D_STATUS;
                end
            end
            TIC_D_SEND: begin
                if (s.img && (fault_seen || link.bus_fault)) begin
                    // A byte on offer is withdrawn; the initiator retries.
                    next_s.data_valid   = 1'b0;
                    next_s.status_check = 1'b1;
                    next_s.status_sense = `TIC_SK_ABORTED;
                    next_s.st           = TIC_D_STATUS;
                end else if (!s.data_valid || link.data_ready) begin
                    if (s.cnt == s.total) begin
                        next_s.data_valid   = 1'b0;
                        next_s.status_check = 1'b0;
                        next_s.status_sense = `TIC_SK_NONE;
                        next_s.st           = TIC_D_STATUS;
                    end else begin
                        next_s.data_valid = 1'b1;
                        if (s.img) begin
                            next_s.data_byte = img_data_i;
                        end else begin
                            next_s.data_byte = rec_byte(s.cnt[2:0],
                                no_disconnect_during_transfer_i);
                        end
                        next_s.cnt = s.cnt + 24'h000001;
                    end
                end
            end
            TIC_D_STATUS: begin
                next_s.status_valid = 1'b1;
                next_s.cdb_ready    = 1'b1;
                next_s.st           = TIC_D_IDLE;
            end
            default: begin
                next_s.st = TIC_D_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s.st           <= TIC_D_IDLE;
            s.cdb          <= '0;
            s.idx          <= 4'h0;
            s.len          <= 4'h0;
            s.cnt          <= 24'h000000;
            s.total        <= 24'h000000;
            s.img          <= 1'b0;
            s.cdb_ready    <= 1'b0;
            s.data_valid   <= 1'b0;
            s.data_byte    <= 8'h00;
            s.status_valid <= 1'b0;
            s.status_check <= 1'b0;
            s.status_sense <= `TIC_SK_NONE;
            busy_o         <= 1'b0;
        end else begin
            s      <= next_s;
            busy_o <= busy;
        end
    end

    // The image memory is read without latency at the byte counter, so
    // the next byte is ready whenever the link accepts the current one.
    assign img_addr_o        = s.cnt[18:0];
    assign link.cdb_ready    = s.cdb_ready;
    assign link.data_valid   = s.data_valid;
    assign link.data_byte    = s.data_byte;
    assign link.status_valid = s.status_valid;
    assign link.status_check = s.status_check;
    assign link.status_sense = s.status_sense;

endmodule
`default_nettype wire

// >>> src/tic_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tic_regs.svh"

module tic_host (
    input  wire logic                ref_clk_i,
    input  wire logic                arst_n_i,
    input  wire logic [11:0]         paddr_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [31:0]         pwdata_i,
    output logic [31:0]              prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    output logic                     irq_o,
    output logic                     rx_valid_o,
    output tic_pkg::tic_byte_t       rx_byte_o,
    input  wire logic                rx_ready_i,
    input  wire logic                bus_fault_i,
    tic_if.host                      link
);
    import tic_pkg::*;

    tic_host_s s;
    tic_host_s next_s;
    logic      acc;
    logic      wr;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;

    function automatic tic_byte_t cdb_byte(input logic [3:0]  i,
                                           input logic        op,
                                           input logic [26:0] a);
        cdb_byte = 8'h00;
        if (!op) begin
            if (i == 4'h0) cdb_byte = `TIC_OP_LIMITS;
        end else begin
            case (i)
                4'h0:    cdb_byte = `TIC_OP_RDBUF;
                4'h1:    cdb_byte = {5'h00, a[26:24]};
                4'h6:    cdb_byte = a[23:16];
                4'h7:    cdb_byte = a[15:8];
                4'h8:    cdb_byte = a[7:0];
                default: cdb_byte = 8'h00;
            endcase
        end
    endfunction

    always_comb begin
        next_s           = s;
        acc              = psel_i && penable_i && s.pready;
        wr               = acc && pwrite_i;
        irq_set          = 2'h0;
        irq_clr          = 2'h0;
        next_s.pready    = psel_i && penable_i && !s.pready;
        next_s.pslverr   = 1'b0;
        next_s.bus_fault = bus_fault_i;
        if (psel_i && penable_i && !s.pready) begin
            next_s.prdata = 32'h00000000;
            if (paddr_i == `TIC_CMD) begin
                next_s.prdata[`TIC_CMD_BUSY] = (s.st != TIC_H_IDLE);
                next_s.prdata[`TIC_CMD_OP]   = s.op;
            end else if (paddr_i == `TIC_ALLOC) begin
                next_s.prdata = {5'h00, s.alloc};
            end else if (paddr_i == `TIC_STATUS) begin
                next_s.prdata = {s.rx_cnt, 3'h0, s.check, s.sense};
            end else if (paddr_i == `TIC_IRQ_STAT) begin
                next_s.prdata = {30'h00000000, s.irq_stat};
            end else if (paddr_i == `TIC_IRQ_MASK) begin
                next_s.prdata = {30'h00000000, s.irq_mask};
            end else if (paddr_i == `TIC_LIMITS_MAX) begin
                next_s.prdata = {8'h00, s.lim_max};
            end else if (paddr_i == `TIC_LIMITS_MIN) begin
                next_s.prdata = {16'h0000, s.lim_min};
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        if (wr && paddr_i == `TIC_ALLOC) begin
            next_s.alloc = pwdata_i[26:0];
        end else if (wr && paddr_i == `TIC_IRQ_STAT) begin
            irq_clr = pwdata_i[1:0];
        end else if (wr && paddr_i == `TIC_IRQ_MASK) begin
            next_s.irq_mask = pwdata_i[1:0];
        end
        if (s.rx_valid && rx_ready_i) begin
            next_s.rx_valid = 1'b0;
        end
        case (s.st)
            TIC_H_IDLE: begin
                // A start while a command is running is ignored.
                if (wr && paddr_i == `TIC_CMD && pwdata_i[`TIC_CMD_GO]) begin
                    next_s.op        = pwdata_i[`TIC_CMD_OP];
                    next_s.idx       = 4'h0;
                    next_s.cdb_valid = 1'b1;
                    next_s.cdb_byte  = cdb_byte(4'h0, pwdata_i[`TIC_CMD_OP],
                                                s.alloc);
                    next_s.rx_cnt    = 24'h000000;
                    next_s.st        = TIC_H_CDB;
                end
            end
            TIC_H_CDB: begin
                if (s.cdb_valid && link.cdb_ready) begin
                    if (s.idx == (s.op ? `TIC_LEN_GRP1 : `TIC_LEN_GRP0) - 4'h1)
                    begin
                        next_s.cdb_valid = 1'b0;
                        next_s.st        = TIC_H_WAIT;
                    end else begin
                        next_s.idx      = s.idx + 4'h1;
                        next_s.cdb_byte = cdb_byte(s.idx + 4'h1, s.op,
                                                   s.alloc);
                    end
                end
            end
            TIC_H_WAIT: begin
                if (link.data_valid && s.take) begin
                    next_s.rx_cnt = s.rx_cnt + 24'h000001;
                    if (s.op) begin
                        next_s.rx_valid = 1'b1;
                        next_s.rx_byte  = link.data_byte;
                    end else if (s.rx_cnt == 24'h000001) begin
                        next_s.lim_max[23:16] = link.data_byte;
                    end else if (s.rx_cnt == 24'h000002) begin
                        next_s.lim_max[15:8] = link.data_byte;
                    end else if (s.rx_cnt == 24'h000003) begin
                        next_s.lim_max[7:0] = link.data_byte;
                    end else if (s.rx_cnt == 24'h000004) begin
                        next_s.lim_min[15:8] = link.data_byte;
                    end else if (s.rx_cnt == 24'h000005) begin
                        next_s.lim_min[7:0] = link.data_byte;
                    end
                end
                if (link.status_valid) begin
                    // Software retries after an aborted termination.
                    next_s.check                  = link.status_check;
                    next_s.sense                  = link.status_sense;
                    irq_set[`TIC_IRQ_DONE]        = 1'b1;
                    irq_set[`TIC_IRQ_CHECK]       = link.status_check;
                    next_s.st                     = TIC_H_IDLE;
                end
            end
            default: begin
                next_s.st = TIC_H_IDLE;
            end
        endcase
        // A new event in the cycle of its clear keeps the bit set.
        next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
        next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
        next_s.take     = !next_s.rx_valid;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s.st        <= TIC_H_IDLE;
            s.idx       <= 4'h0;
            s.op        <= 1'b0;
            s.cdb_valid <= 1'b0;
            s.cdb_byte  <= 8'h00;
            s.alloc     <= `TIC_ALLOC_RST;
            s.irq_stat  <= 2'h0;
            s.irq_mask  <= 2'h0;
            s.irq       <= 1'b0;
            s.check     <= 1'b0;
            s.sense     <= `TIC_SK_NONE;
            s.rx_cnt    <= 24'h000000;
            s.lim_max   <= 24'h000000;
            s.lim_min   <= 16'h0000;
            s.rx_valid  <= 1'b0;
            s.rx_byte   <= 8'h00;
            s.take      <= 1'b1;
            s.bus_fault <= 1'b0;
            s.pready    <= 1'b0;
            s.prdata    <= 32'h00000000;
            s.pslverr   <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_o        = s.prdata;
    assign pready_o        = s.pready;
    assign pslverr_o       = s.pslverr;
    assign irq_o           = s.irq;
    assign rx_valid_o      = s.rx_valid;
    assign rx_byte_o       = s.rx_byte;
    assign link.cdb_valid  = s.cdb_valid;
    assign link.cdb_byte   = s.cdb_byte;
    assign link.data_ready = s.take;
    assign link.bus_fault  = s.bus_fault;

endmodule
`default_nettype wire

// >>> test/tic_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tic_link_properties (
    input wire logic       ref_clk_i,
    input wire logic       arst_n_i,
    input wire logic       cdb_valid,
    input wire logic [7:0] cdb_byte,
    input wire logic       cdb_ready,
    input wire logic       data_valid,
    input wire logic [7:0] data_byte,
    input wire logic       data_ready,
    input wire logic       status_valid,
    input wire logic       status_check,
    input wire logic [3:0] status_sense,
    input wire logic       bus_fault
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Opcode of the command in flight and count of returned bytes taken.
    logic [7:0] op_q;
    logic       fst_q;
    logic [2:0] cnt_q;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_q <= 8'h00;
            fst_q <= 1'b1;
            cnt_q <= 3'h0;
        end else begin
            if (cdb_valid && cdb_ready && fst_q)
                op_q <= cdb_byte;
            fst_q <= status_valid | (fst_q & ~(cdb_valid & cdb_ready));
            if (status_valid)
                cnt_q <= 3'h0;
            else if (data_valid && data_ready && cnt_q != 3'h7)
                cnt_q <= cnt_q + 3'h1;
        end
    end
    cdb_hold_a: assert property (cdb_valid && !cdb_ready |=>
        cdb_valid && $stable(cdb_byte)) else $error("descriptor byte dropped");
    data_hold_a: assert property (data_valid && !data_ready |=>
        (data_valid && $stable(data_byte)) or
        (!data_valid ##1 (status_valid && status_check)))
        else $error("data byte dropped");
    rec_reserved_a: assert property (op_q == 8'h05 && data_valid &&
        cnt_q == 3'h0 |-> data_byte == 8'h00)
        else $error("record byte 0 not zero");
    rec_max_a: assert property (op_q == 8'h05 && data_valid &&
        cnt_q == 3'h1 |-> data_byte inside {8'h03, 8'h02})
        else $error("max length high byte wrong");
    rec_min_a: assert property (op_q == 8'h05 && data_valid &&
        cnt_q >= 3'h4 |-> data_byte == {7'h00, cnt_q[0]})
        else $error("min length wrong");
    rec_len_a: assert property (op_q == 8'h05 && data_valid |->
        cnt_q < 3'h6) else $error("record too long");
    limits_done_a: assert property (op_q == 8'h05 && data_valid &&
        data_ready && cnt_q == 3'h5 |-> ##2 status_valid && !status_check)
        else $error("no good status");
    status_pulse_a: assert property (status_valid |=> !status_valid)
        else $error("status longer than a pulse");
    check_sense_a: assert property (status_valid && status_check
        |-> status_sense inside {4'h5, 4'hB}) else $error("bad sense key");
    clean_sense_a: assert property (status_valid && !status_check |->
        status_sense == 4'h0) else $error("sense without check");
    fault_abort_a: assert property (op_q == 8'h3C && data_valid &&
        bus_fault |-> ##[1:4] (status_valid && status_check &&
        status_sense == 4'hB)) else $error("fault not aborted");
    limits_c: cover property (op_q == 8'h05 && status_valid);
    illegal_c: cover property (status_valid && status_sense == 4'h5);
    aborted_c: cover property (status_valid && status_sense == 4'hB);
endmodule
`default_nettype wire

// >>> test/tape_info_command_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, s) begin comparisons++; if ((s) !== (x)) begin \
    miscompares++; $display("unexpected %s exp %0h got %0h", n, x, s); end end
module tape_info_command_handler_test;
    import tic_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        rx_ready = 1'b0;
    logic        bfault = 1'b0;
    logic        nd = 1'b0;
    logic        hw_fault = 1'b0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        rx_valid;
    tic_byte_t   rx_byte;
    logic [18:0] img_addr;
    logic        busy;
    logic [31:0] rnd = 32'h63c8;
    logic        msk = 1'b0;
    logic        img = 1'b0;
    int          miscompares = 0;
    int          comparisons = 0;
    int          nrx = 0;
    tic_if lk ();
    always #12.5 ref_clk_i = ~ref_clk_i;
    tic_dev #(.IMG_LEN(24'h000010)) tic_dev_i (.ref_clk_i, .arst_n_i,
        .link(lk), .no_disconnect_during_transfer_i(nd),
        .hw_fault_i(hw_fault), .img_data_i(img_addr[7:0] ^ 8'hA5),
        .img_addr_o(img_addr), .busy_o(busy));
    tic_host tic_host_i (.ref_clk_i, .arst_n_i, .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq), .rx_valid_o(rx_valid),
        .rx_byte_o(rx_byte), .rx_ready_i(rx_ready),
        .bus_fault_i(bfault), .link(lk));
    tic_link_properties tic_link_properties_i (.ref_clk_i, .arst_n_i,
        .cdb_valid(lk.cdb_valid), .cdb_byte(lk.cdb_byte),
        .cdb_ready(lk.cdb_ready), .data_valid(lk.data_valid),
        .data_byte(lk.data_byte), .data_ready(lk.data_ready),
        .status_valid(lk.status_valid), .status_check(lk.status_check),
        .status_sense(lk.status_sense), .bus_fault(lk.bus_fault));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Random stalls on the user side keep the holding register busy.
    always @(posedge ref_clk_i) begin
        rnd = xs(rnd);
        rx_ready <= rnd[0] | rnd[1];
    end
    // A byte seen here with ready high is taken at the next rising edge.
    always @(negedge ref_clk_i) begin
        if (rx_valid === 1'b1 && rx_ready) begin
            if (img)
                `CHK("rx_byte", nrx[7:0] ^ 8'hA5, rx_byte)
            nrx++;
        end
    end
    task automatic summarize;
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        q = pslverr ? 32'hDEAD0000 | prdata : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic run(input logic op, input logic [31:0] alloc,
                       input logic f_nd, input int flt,
                       input logic [3:0] sk);
        img = op;
        nrx = 0;
        nd <= f_nd;
        apb(1'b1, 12'h004, alloc);
        apb(1'b1, 12'h000, {30'h0, op, 1'b1});
        if (flt != 0) begin
            wait (nrx == 5);
            @(posedge ref_clk_i);
            hw_fault <= (flt == 1);
            bfault <= (flt == 2);
        end
        do apb(1'b0, 12'h00C, 32'h0); while (q[1:0] == 2'b00);
        `CHK("irq_stat", {30'h0, sk != 4'h0, 1'b1}, q)
        `CHK("irq", msk, irq)
        hw_fault <= 1'b0;
        bfault <= 1'b0;
        apb(1'b0, 12'h008, 32'h0);
        `CHK("sense", {sk != 4'h0, sk}, q[4:0])
        if (op && flt == 0)
            `CHK("count", (sk == 4'h0) ? 24'h10 : 24'h0, q[31:8])
        apb(1'b0, 12'h000, 32'h0);
        `CHK("cmd", {30'h0, op, 1'b0}, q)
        `CHK("busy", 1'b0, busy)
        if (!op) begin
            apb(1'b0, 12'h014, 32'h0);
            `CHK("max", f_nd ? 24'h028000 : 24'h03C000, q[23:0])
            apb(1'b0, 12'h018, 32'h0);
            `CHK("min", 16'h0001, q[15:0])
        end
        apb(1'b1, 12'h00C, 32'h3);
        repeat (2) @(posedge ref_clk_i);
        `CHK("irq_clear", 1'b0, irq)
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        miscompares++;
        summarize;
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        apb(1'b0, 12'h004, 32'h0);
        `CHK("alloc_reset", 32'h01054E28, q)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("mask_reset", 32'h0, q)
        apb(1'b0, 12'h01C, 32'h0);
        `CHK("unmapped", 32'hDEAD0000, q)
        run(1'b0, 32'h01000010, 1'b0, 0, 4'h0);
        apb(1'b1, 12'h010, 32'h3);
        msk = 1'b1;
        run(1'b0, 32'h01000010, 1'b1, 0, 4'h0);
        run(1'b1, 32'h01000010, 1'b0, 0, 4'h0);
        run(1'b1, 32'h01000011, 1'b0, 0, 4'h5);
        run(1'b1, 32'h02000010, 1'b0, 0, 4'h5);
        run(1'b1, 32'h01000010, 1'b0, 1, 4'hB);
        run(1'b1, 32'h01000010, 1'b0, 2, 4'hB);
        run(1'b1, 32'h01000010, 1'b0, 0, 4'h0);
        summarize;
    end
endmodule
`default_nettype wire
